// >>> rtl/arr_pkg.sv
// constants shared by the converter result register block
package arr_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] PRI_RESULT_ADDR = 32'h4003_0020;
	localparam logic [31:0] SEC_RESULT_ADDR = 32'h4003_0024;
	localparam logic [31:0] PRI_OFFSET_ADDR = 32'h4003_0030;
	localparam logic [31:0] PRI_CFG_ADDR = 32'h4003_0050;
	localparam logic [31:0] PRI_LIMIT_ADDR = 32'h4003_0054;
	localparam logic [31:0] SEC_CFG_ADDR = 32'h4003_0058;
	localparam logic [31:0] PRI_COUNT_ADDR = 32'h4003_005C;
	localparam logic [31:0] FLAGS_ADDR = 32'h4003_0060;
	localparam logic [31:0] IRQ_STATUS_ADDR = 32'h4003_0064;
	localparam logic [31:0] IRQ_MASK_ADDR = 32'h4003_0068;

	// ----------------------------------------------------------------
	// reset values and field layout
	// ----------------------------------------------------------------
	localparam logic [31:0] RESULT_RESET = 32'h0000_0001;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [15:0] LIMIT_RESET = 16'h0000;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam int VALID_BIT = 0;
	localparam int GAIN_LSB = 0;
	localparam int GAIN_W = 4;
	localparam int CODE_BIT = 4;
	localparam int RCEN_BIT = 5;
	localparam int CAL_BIT = 6;
	localparam int SEC_CODE_BIT = 0;
	localparam int OFFSET_W = 24;
	localparam int OFFSET_SIGN_BIT = 23;
	localparam int CFG_W = 8;
	// gain code 9 selects a gain of 512, the largest
	localparam logic [3:0] MAX_GAIN_SEL = 4'h9;
	// lowest result-word bit still carried at a gain of 1
	localparam int GAIN1_LSB = 10;

	// ----------------------------------------------------------------
	// interrupt status bits
	// ----------------------------------------------------------------
	localparam int IRQ_W = 4;
	localparam int IRQ_PRI_READY = 0;
	localparam int IRQ_SEC_READY = 1;
	localparam int IRQ_PRI_LOST = 2;
	localparam int IRQ_SEC_LOST = 3;

	// ----------------------------------------------------------------
	// bus answers and register selector
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [3:0] {
		REG_NONE = 4'b0000,
		REG_PRI_RESULT = 4'b0001,
		REG_SEC_RESULT = 4'b0010,
		REG_PRI_OFFSET = 4'b0011,
		REG_PRI_CFG = 4'b0100,
		REG_PRI_LIMIT = 4'b0101,
		REG_SEC_CFG = 4'b0110,
		REG_PRI_COUNT = 4'b0111,
		REG_FLAGS = 4'b1000,
		REG_IRQ_STATUS = 4'b1001,
		REG_IRQ_MASK = 4'b1010
	} arr_reg_t;

endpackage

// >>> rtl/arr_result_regs.sv
// converter result, offset and control registers behind an axi4-lite slave
`timescale 1ns/1ps

// Summary of operation
// - primary result 32 bits, bit0 invalid flag outside calibration
// - primary result placed by selected gain
// - gain 512 data in bits 22..1
// - primary code format twos complement or unipolar
// - primary write blocked while ready, unless core off
// - secondary write blocked while ready, unless core off
// - simultaneous writes; ready set on write
// - secondary reconfiguration while busy resets only secondary converter
// - after reset, secondary waits for settled data
// - counter on: write only at limit, unless core off
// - secondary result has fixed data width
// - secondary result resets 1, bit0 invalid
// - offset coefficient 24 bits, bit 23 sign
// - calibration outcome left in result bits 23..0
// - interrupt every conversion, or at limit only
module arr_result_regs #(
	parameter int ADDR_W = 32,
	parameter int CNT_W = 16,
	parameter int SEC_SETTLE = 3,
	parameter logic [23:0] OFFSET_RESET = 24'h00_0000
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// converter side, same clock
	input wire logic core_powered,
	input wire logic pri_conv_valid,
	input wire logic [30:0] pri_conv_data,
	input wire logic pri_data_ok,
	input wire logic sec_conv_valid,
	input wire logic [30:0] sec_conv_data,
	input wire logic sec_data_ok,
	input wire logic sec_busy,
	// converter control
	output logic [3:0] pri_gain_sel,
	output logic pri_cal_mode,
	output logic sec_conv_reset,
	// flags and interrupt
	output logic primary_ready_flag,
	output logic secondary_ready_flag,
	output logic irq
);

	// ----------------------------------------------------------------
	// decode and helpers
	// ----------------------------------------------------------------
	function automatic arr_pkg::arr_reg_t arr_decode(input logic [ADDR_W-1:0] a);
		logic [31:0] w;
		w = 32'(a);
		case (w)
			arr_pkg::PRI_RESULT_ADDR: arr_decode = arr_pkg::REG_PRI_RESULT;
			arr_pkg::SEC_RESULT_ADDR: arr_decode = arr_pkg::REG_SEC_RESULT;
			arr_pkg::PRI_OFFSET_ADDR: arr_decode = arr_pkg::REG_PRI_OFFSET;
			arr_pkg::PRI_CFG_ADDR: arr_decode = arr_pkg::REG_PRI_CFG;
			arr_pkg::PRI_LIMIT_ADDR: arr_decode = arr_pkg::REG_PRI_LIMIT;
			arr_pkg::SEC_CFG_ADDR: arr_decode = arr_pkg::REG_SEC_CFG;
			arr_pkg::PRI_COUNT_ADDR: arr_decode = arr_pkg::REG_PRI_COUNT;
			arr_pkg::FLAGS_ADDR: arr_decode = arr_pkg::REG_FLAGS;
			arr_pkg::IRQ_STATUS_ADDR: arr_decode = arr_pkg::REG_IRQ_STATUS;
			arr_pkg::IRQ_MASK_ADDR: arr_decode = arr_pkg::REG_IRQ_MASK;
			default: arr_decode = arr_pkg::REG_NONE;
		endcase
	endfunction
	// byte-lane merge of a write into an old value
	function automatic logic [31:0] arr_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) v[i*8 +: 8] = nw[i*8 +: 8];
		end
		return v;
	endfunction
	// unipolar format is offset binary: the sign bit turned round
	function automatic logic [30:0] arr_code(input logic [30:0] v, input logic uni);
		arr_code = uni ? {~v[30], v[29:0]} : v;
	endfunction
	// shift by gain and clear bits below the gain's resolution
	function automatic logic [30:0] arr_place(input logic [30:0] raw, input logic [3:0] g);
		logic [3:0] s;
		logic [30:0] v;
		int lsb;
		s = (g > arr_pkg::MAX_GAIN_SEL) ? arr_pkg::MAX_GAIN_SEL : g;
		v = 31'($signed(raw) >>> s);
		lsb = arr_pkg::GAIN1_LSB - int'(s);
		for (int i = 0; i < 31; i++) begin
			if (i + 1 < lsb) v[i] = 1'b0;
		end
		return v;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic aw_hold_reg, w_hold_reg, awready_reg, wready_reg, bvalid_reg;
	logic arready_reg, rvalid_reg, pri_ready_reg, sec_ready_reg, sec_reset_reg, irq_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg, rdata_reg, pri_result_reg, sec_result_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [23:0] offset_reg;
	logic [7:0] pri_cfg_reg, sec_cfg_reg, settle_reg;
	logic [CNT_W-1:0] limit_reg, count_reg;
	logic [arr_pkg::IRQ_W-1:0] status_reg, mask_reg;

	logic do_write, rd_fire, rcen, pri_hit, pri_write, pri_lost;
	logic sec_take, sec_write, sec_lost, sec_reconfig;
	arr_pkg::arr_reg_t wr_sel, rd_sel;
	logic [31:0] pri_word, rd_value, wr_value;

	assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
	assign wr_sel = arr_decode(awaddr_reg);
	assign rd_sel = arr_decode(s_axi_araddr);
	assign rd_fire = s_axi_arvalid & arready_reg;
	assign rcen = pri_cfg_reg[arr_pkg::RCEN_BIT];

	// ----------------------------------------------------------------
	// primary converter path
	// ----------------------------------------------------------------
	// counter is ignored while the core is off, so every result lands
	assign pri_hit = ~rcen | ~core_powered |
		((count_reg + CNT_W'(1)) == limit_reg);
	assign pri_write = pri_conv_valid & pri_hit & (~pri_ready_reg | ~core_powered);
	assign pri_lost = pri_conv_valid & pri_hit & pri_ready_reg & core_powered;
	always_comb begin
		if (pri_cfg_reg[arr_pkg::CAL_BIT]) begin
			// calibration outcome sits in 23..0, sign extended above
			pri_word = 32'($signed(pri_conv_data[arr_pkg::OFFSET_W-1:0]));
		end else begin
			pri_word = {arr_code(arr_place(pri_conv_data,
				pri_cfg_reg[arr_pkg::GAIN_LSB +: arr_pkg::GAIN_W]),
				pri_cfg_reg[arr_pkg::CODE_BIT]), ~pri_data_ok};
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pri_result_reg <= arr_pkg::RESULT_RESET;
		end else if (pri_write) begin
			pri_result_reg <= pri_word;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= '0;
		end else if (!rcen) begin
			count_reg <= '0;
		end else if (pri_conv_valid && core_powered) begin
			count_reg <= pri_hit ? '0 : count_reg + CNT_W'(1);
		end
	end
	// a new result wins over a clearing read in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pri_ready_reg <= 1'b0;
		end else if (pri_write) begin
			pri_ready_reg <= 1'b1;
		end else if (rd_fire && rd_sel == arr_pkg::REG_PRI_RESULT) begin
			pri_ready_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// secondary converter path
	// ----------------------------------------------------------------
	assign sec_reconfig = do_write & (wr_sel == arr_pkg::REG_SEC_CFG) & sec_busy;
	assign sec_take = sec_conv_valid & (settle_reg == 8'h00);
	assign sec_write = sec_take & (~sec_ready_reg | ~core_powered);
	assign sec_lost = sec_take & sec_ready_reg & core_powered;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sec_result_reg <= arr_pkg::RESULT_RESET;
		end else if (sec_write) begin
			sec_result_reg <= {arr_code(sec_conv_data,
				sec_cfg_reg[arr_pkg::SEC_CODE_BIT]), ~sec_data_ok};
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sec_ready_reg <= 1'b0;
		end else if (sec_write) begin
			sec_ready_reg <= 1'b1;
		end else if (rd_fire && rd_sel == arr_pkg::REG_SEC_RESULT) begin
			sec_ready_reg <= 1'b0;
		end
	end
	// only the secondary converter restarts; primary logic never looks here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sec_reset_reg <= 1'b0;
			settle_reg <= 8'h00;
		end else begin
			sec_reset_reg <= sec_reconfig;
			if (sec_reconfig) begin
				settle_reg <= 8'(SEC_SETTLE);
			end else if (sec_conv_valid && settle_reg != 8'h00) begin
				settle_reg <= settle_reg - 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_comb begin
		case (wr_sel)
			arr_pkg::REG_PRI_OFFSET: wr_value = 32'(offset_reg);
			arr_pkg::REG_PRI_CFG: wr_value = 32'(pri_cfg_reg);
			arr_pkg::REG_PRI_LIMIT: wr_value = 32'(limit_reg);
			arr_pkg::REG_SEC_CFG: wr_value = 32'(sec_cfg_reg);
			arr_pkg::REG_IRQ_MASK: wr_value = 32'(mask_reg);
			default: wr_value = 32'h0000_0000;
		endcase
		wr_value = arr_merge(wr_value, wdata_reg, wstrb_reg);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			offset_reg <= OFFSET_RESET;
			pri_cfg_reg <= arr_pkg::CFG_RESET;
			sec_cfg_reg <= arr_pkg::CFG_RESET;
			limit_reg <= CNT_W'(arr_pkg::LIMIT_RESET);
			mask_reg <= arr_pkg::MASK_RESET;
		end else if (do_write) begin
			case (wr_sel)
				arr_pkg::REG_PRI_OFFSET: offset_reg <= wr_value[arr_pkg::OFFSET_W-1:0];
				arr_pkg::REG_PRI_CFG: pri_cfg_reg <= wr_value[arr_pkg::CFG_W-1:0];
				arr_pkg::REG_PRI_LIMIT: limit_reg <= wr_value[CNT_W-1:0];
				arr_pkg::REG_SEC_CFG: sec_cfg_reg <= wr_value[arr_pkg::CFG_W-1:0];
				arr_pkg::REG_IRQ_MASK: mask_reg <= wr_value[arr_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// sticky events; a new event wins over a write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			for (int i = 0; i < arr_pkg::IRQ_W; i++) begin
				if (do_write && wr_sel == arr_pkg::REG_IRQ_STATUS && wstrb_reg[0] &&
					wdata_reg[i]) begin
					status_reg[i] <= 1'b0;
				end
			end
			if (pri_write) status_reg[arr_pkg::IRQ_PRI_READY] <= 1'b1;
			if (sec_write) status_reg[arr_pkg::IRQ_SEC_READY] <= 1'b1;
			if (pri_lost) status_reg[arr_pkg::IRQ_PRI_LOST] <= 1'b1;
			if (sec_lost) status_reg[arr_pkg::IRQ_SEC_LOST] <= 1'b1;
			irq_reg <= |(status_reg & mask_reg);
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite write channels
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			awready_reg <= 1'b0;
		end else if (s_axi_awvalid && awready_reg) begin
			aw_hold_reg <= 1'b1;
			awaddr_reg <= s_axi_awaddr;
			awready_reg <= 1'b0;
		end else if (do_write) begin
			aw_hold_reg <= 1'b0;
		end else if (!aw_hold_reg && !bvalid_reg) begin
			awready_reg <= 1'b1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_reg <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			wready_reg <= 1'b0;
		end else if (s_axi_wvalid && wready_reg) begin
			w_hold_reg <= 1'b1;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
			wready_reg <= 1'b0;
		end else if (do_write) begin
			w_hold_reg <= 1'b0;
		end else if (!w_hold_reg && !bvalid_reg) begin
			wready_reg <= 1'b1;
		end
	end
	// result registers, count and flags are read-only: writes answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= arr_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			case (wr_sel)
				arr_pkg::REG_PRI_OFFSET, arr_pkg::REG_PRI_CFG, arr_pkg::REG_PRI_LIMIT,
				arr_pkg::REG_SEC_CFG, arr_pkg::REG_IRQ_STATUS, arr_pkg::REG_IRQ_MASK:
					bresp_reg <= arr_pkg::RESP_OKAY;
				default: bresp_reg <= arr_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_bready && bvalid_reg) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	always_comb begin
		case (rd_sel)
			arr_pkg::REG_PRI_RESULT: rd_value = pri_result_reg;
			arr_pkg::REG_SEC_RESULT: rd_value = sec_result_reg;
			arr_pkg::REG_PRI_OFFSET: rd_value = 32'(offset_reg);
			arr_pkg::REG_PRI_CFG: rd_value = 32'(pri_cfg_reg);
			arr_pkg::REG_PRI_LIMIT: rd_value = 32'(limit_reg);
			arr_pkg::REG_SEC_CFG: rd_value = 32'(sec_cfg_reg);
			arr_pkg::REG_PRI_COUNT: rd_value = 32'(count_reg);
			arr_pkg::REG_FLAGS: rd_value = 32'({settle_reg != 8'h00, sec_ready_reg,
				pri_ready_reg});
			arr_pkg::REG_IRQ_STATUS: rd_value = 32'(status_reg);
			arr_pkg::REG_IRQ_MASK: rd_value = 32'(mask_reg);
			default: rd_value = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= arr_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_value;
			rresp_reg <= (rd_sel == arr_pkg::REG_NONE) ? arr_pkg::RESP_SLVERR :
				arr_pkg::RESP_OKAY;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end else if (!rvalid_reg) begin
			arready_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign pri_gain_sel = pri_cfg_reg[arr_pkg::GAIN_LSB +: arr_pkg::GAIN_W];
	assign pri_cal_mode = pri_cfg_reg[arr_pkg::CAL_BIT];
	assign sec_conv_reset = sec_reset_reg;
	assign primary_ready_flag = pri_ready_reg;
	assign secondary_ready_flag = sec_ready_reg;
	assign irq = irq_reg;

endmodule

// >>> sim/arr_result_regs_asserts.sv
// port-level checks for the converter result register block
`timescale 1ns/1ps
module arr_result_regs_asserts #(
	parameter int ADDR_W = 32
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// read address channel and read data valid
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// converter side
	input wire logic core_powered,
	input wire logic pri_conv_valid,
	input wire logic sec_conv_valid,
	input wire logic sec_conv_reset,
	input wire logic primary_ready_flag,
	input wire logic secondary_ready_flag
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ----------------------------------------------------------------
	// ready flags
	// ----------------------------------------------------------------
	// a flag may only rise because a conversion was stored
	property p_pri_set;
		$rose(primary_ready_flag) |-> $past(pri_conv_valid) || $past(pri_conv_valid, 2);
	endproperty
	a_pri_set: assert property (p_pri_set)
		else $error("primary flag rose with no conversion");
	property p_sec_set;
		$rose(secondary_ready_flag) |-> $past(sec_conv_valid) || $past(sec_conv_valid, 2);
	endproperty
	a_sec_set: assert property (p_sec_set)
		else $error("secondary flag rose with no conversion");
	// with the core off nothing but secondary settling blocks a result
	property p_pri_off;
		pri_conv_valid && !core_powered |-> ##[1:2] primary_ready_flag;
	endproperty
	a_pri_off: assert property (p_pri_off)
		else $error("primary result not stored with core off");
	property p_sec_off;
		sec_conv_valid && !core_powered |-> ##[1:2] secondary_ready_flag;
	endproperty
	a_sec_off: assert property (p_sec_off)
		else $error("secondary result not stored with core off");
	property p_rd_clr;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == arr_pkg::PRI_RESULT_ADDR
			&& !pri_conv_valid |-> ##2 !primary_ready_flag;
	endproperty
	a_rd_clr: assert property (p_rd_clr)
		else $error("primary flag not cleared by result read");

	// ----------------------------------------------------------------
	// secondary reset and bus answer
	// ----------------------------------------------------------------
	property p_rst_pulse;
		sec_conv_reset |=> !sec_conv_reset;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse)
		else $error("secondary reset longer than one cycle");
	property p_settle;
		sec_conv_reset |=> (!$rose(secondary_ready_flag)) [*2];
	endproperty
	a_settle: assert property (p_settle)
		else $error("secondary result stored while settling");
	property p_ar_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_ar_answer: assert property (p_ar_answer)
		else $error("read data not returned one cycle after address");
endmodule

// >>> sim/arr_result_regs_tb.sv
// self-checking bench for the converter result register block
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module arr_result_regs_tb;
	logic aclk = 0;
	logic aresetn = 0;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic [3:0] s_axi_wstrb = 4'hf, pri_gain_sel, gg;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, pri_cal_mode, sec_conv_reset, irq, u;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic core_powered = 1, pri_conv_valid = 0, pri_data_ok = 1, sec_conv_valid = 0;
	logic sec_data_ok = 1, sec_busy = 0, primary_ready_flag, secondary_ready_flag;
	logic [30:0] pri_conv_data = 0, sec_conv_data = 0, x;
	int failures = 0, checks_done = 0, resets_seen = 0;

	arr_result_regs DUT (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.core_powered, .pri_conv_valid, .pri_conv_data, .pri_data_ok, .sec_conv_valid,
		.sec_conv_data, .sec_data_ok, .sec_busy, .pri_gain_sel, .pri_cal_mode,
		.sec_conv_reset, .primary_ready_flag, .secondary_ready_flag, .irq
	);

	always #10 aclk = ~aclk;
	always @(posedge aclk) if (sec_conv_reset === 1'b1) resets_seen++;

	task automatic complete_run;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic tmo;
		failures++;
		$display("[FAIL] %0t wait ran out", $time);
		complete_run();
	endtask

	// ----------------------------------------------------------------
	// bus and converter drivers
	// ----------------------------------------------------------------
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic b;
		b = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (int n = 0; n < 60 && !b; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin
				b = 1;
				rs = s_axi_bresp;
				s_axi_bready <= 0;
			end
		end
		if (!b) tmo();
		@(posedge aclk);
	endtask

	task automatic rdt(input logic [31:0] a);
		logic got;
		got = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (int n = 0; n < 60 && !got; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin
				got = 1;
				rd = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 0;
			end
		end
		if (!got) tmo();
		@(posedge aclk);
	endtask

	task automatic rchk(input logic [31:0] a, input logic [31:0] e);
		rdt(a);
		`CHK(rd, e)
	endtask

	// one-cycle pulses, then room for the flags and irq to land
	task automatic conv(input logic p, input logic s, input logic [30:0] a, input logic [30:0] b);
		pri_conv_valid <= p;
		sec_conv_valid <= s;
		pri_conv_data <= a;
		sec_conv_data <= b;
		@(posedge aclk);
		pri_conv_valid <= 0;
		sec_conv_valid <= 0;
		repeat (2) @(posedge aclk);
	endtask

	// gain shifts the word right; lanes under the gain's floor are cleared
	function automatic logic [31:0] pexp(input logic [30:0] r, input logic [3:0] g,
		input logic un, input logic ok);
		logic [30:0] v;
		int s;
		s = (g > 4'h9) ? 9 : int'(g);
		v = $signed(r) >>> s;
		for (int i = 0; i < 31; i++) if (i + 1 < 10 - s) v[i] = 0;
		v[30] = v[30] ^ un;
		return {v, ~ok};
	endfunction

	// software-side offset coefficient from a shorted-input result
	function automatic logic [31:0] ofs(input logic [31:0] r, input int g, input int gc);
		return 32'(($signed(r) / 32) * g * (32'sh0000_4000 / gc));
	endfunction

	initial begin
		repeat (20000) @(posedge aclk);
		tmo();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		x = 31'($urandom(32'hd4f8277e));
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		rchk(arr_pkg::PRI_RESULT_ADDR, 32'h0000_0001);
		rchk(arr_pkg::SEC_RESULT_ADDR, 32'h0000_0001);
		rchk(arr_pkg::PRI_OFFSET_ADDR, 32'h0000_0000);
		$display("test reset values done");
		for (int g = 0; g < 11; g++) begin
			gg = 4'(g);
			u = 1'($urandom);
			x = (g == 9) ? 31'h4000_0000 : 31'($urandom);
			pri_data_ok <= 1'($urandom);
			wr(arr_pkg::PRI_CFG_ADDR, {27'h0, u, gg});
			`CHK(pri_gain_sel, gg)
			conv(1, 0, x, 0);
			`CHK(primary_ready_flag, 1'b1)
			rchk(arr_pkg::PRI_RESULT_ADDR, pexp(x, gg, u, pri_data_ok));
			`CHK(primary_ready_flag, 1'b0)
		end
		$display("test gain placement done");
		pri_data_ok <= 1;
		wr(arr_pkg::PRI_CFG_ADDR, 32'h0000_0005);
		wr(arr_pkg::IRQ_STATUS_ADDR, 32'h0000_000f);
		conv(1, 1, 31'h1234_5678, 31'h0000_0abc);
		`CHK({primary_ready_flag, secondary_ready_flag}, 2'b11)
		conv(1, 1, 31'h0555_0000, 31'h0000_0123);
		rchk(arr_pkg::PRI_RESULT_ADDR, pexp(31'h1234_5678, 4'h5, 0, 1));
		rchk(arr_pkg::SEC_RESULT_ADDR, 32'h0000_1578);
		rchk(arr_pkg::IRQ_STATUS_ADDR, 32'h0000_000f);
		core_powered <= 0;
		conv(1, 1, 31'h0000_1111, 31'h0000_2222);
		conv(1, 1, 31'h0000_3333, 31'h0000_4444);
		rchk(arr_pkg::PRI_RESULT_ADDR, pexp(31'h0000_3333, 4'h5, 0, 1));
		rchk(arr_pkg::SEC_RESULT_ADDR, 32'h0000_8888);
		core_powered <= 1;
		$display("test blocking done");
		wr(arr_pkg::IRQ_STATUS_ADDR, 32'h0000_000f);
		wr(arr_pkg::IRQ_MASK_ADDR, 32'h0000_0001);
		wr(arr_pkg::PRI_LIMIT_ADDR, 32'h0000_0003);
		wr(arr_pkg::PRI_CFG_ADDR, 32'h0000_0020);
		for (int k = 1; k <= 3; k++) begin
			conv(1, 0, 31'(k << 10), 0);
			`CHK(primary_ready_flag, k == 3)
			`CHK(irq, k == 3)
			rchk(arr_pkg::PRI_COUNT_ADDR, 32'(k % 3));
		end
		rchk(arr_pkg::PRI_RESULT_ADDR, pexp(31'h0000_0c00, 4'h0, 0, 1));
		wr(arr_pkg::IRQ_STATUS_ADDR, 32'h0000_0001);
		`CHK(irq, 1'b0)
		wr(arr_pkg::PRI_CFG_ADDR, 32'h0000_0000);
		wr(arr_pkg::IRQ_MASK_ADDR, 32'h0000_0000);
		conv(1, 0, 31'h0000_0007, 0);
		`CHK({primary_ready_flag, irq}, 2'b10)
		rdt(arr_pkg::PRI_RESULT_ADDR);
		$display("test counter and interrupt done");
		sec_busy <= 1;
		wr(arr_pkg::SEC_CFG_ADDR, 32'h0000_0001);
		sec_busy <= 0;
		`CHK(resets_seen, 1)
		rchk(arr_pkg::FLAGS_ADDR, 32'h0000_0004);
		for (int k = 0; k <= 3; k++) begin
			conv(1, 1, 31'(k), 31'(k + 7));
			`CHK(secondary_ready_flag, k == 3)
			`CHK(primary_ready_flag, 1'b1)
			rdt(arr_pkg::PRI_RESULT_ADDR);
		end
		rchk(arr_pkg::SEC_RESULT_ADDR, 32'h8000_0014);
		$display("test reconfiguration done");
		x = 31'($urandom);
		wr(arr_pkg::PRI_OFFSET_ADDR, {1'b1, x});
		rchk(arr_pkg::PRI_OFFSET_ADDR, {8'h00, x[23:0]});
		wr(arr_pkg::PRI_CFG_ADDR, 32'h0000_0040);
		`CHK(pri_cal_mode, 1'b1)
		conv(1, 0, x, 0);
		rchk(arr_pkg::PRI_RESULT_ADDR, {{8{x[23]}}, x[23:0]});
		x = 31'(ofs(rd, 1, 32'sh0000_4000));
		wr(arr_pkg::PRI_OFFSET_ADDR, {1'b0, x});
		rchk(arr_pkg::PRI_OFFSET_ADDR, {8'h00, x[23:0]});
		rchk(32'h4003_0004, 32'h0000_0000);
		`CHK(rs, arr_pkg::RESP_SLVERR)
		wr(arr_pkg::PRI_RESULT_ADDR, 32'h0000_0000);
		`CHK(rs, arr_pkg::RESP_SLVERR)
		$display("test offset and refusals done");
		complete_run();
	end
endmodule

bind arr_result_regs arr_result_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (
	.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.core_powered, .pri_conv_valid, .sec_conv_valid, .sec_conv_reset,
	.primary_ready_flag, .secondary_ready_flag
);
